// *** core/bpm_defines.svh ***
// Purpose: constants for the bus page map access block
// Assumes: included by its bare name
// Notes:   offsets are local I/O byte addresses
`ifndef BPM_DEFINES_SVH
`define BPM_DEFINES_SVH
`define BPM_WIN_FIRST  32'h2008_8000
`define BPM_WIN_LAST   32'h2008_FFFC
`define BPM_ENTRIES    8192
`define BPM_IDX_W      13
`define BPM_FRM_W      20
`define BPM_CACHE_N    16
`define BPM_PTR_W      4
`define BPM_VALID_BIT  31
`define BPM_MBZ_HI     30
`define BPM_MBZ_LO     20
`define BPM_PAGE_LSB   9
`define BPM_BASE_LSB   15
`define BPM_BASE_MSB   28
`define BPM_BASE_RST   14'h0000
`endif

// *** core/bpm_pkg.sv ***
// Purpose: types for the bus page map access block
// Assumes: bpm_defines.svh holds the numbers
// Notes:   state codes are gray along idle, look, fetch
`include "bpm_defines.svh"
package bpm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOOK = 3'b001,
    ST_MRD  = 3'b011,
    ST_MWR  = 3'b010
  } bpm_state_type;

  typedef struct packed {
    logic [`BPM_CACHE_N-1:0]                vld;
    logic [`BPM_CACHE_N-1:0][`BPM_IDX_W-1:0] tag;
    logic [`BPM_CACHE_N-1:0][`BPM_FRM_W-1:0] frm;
    logic [`BPM_PTR_W-1:0]                  ptr;
    logic                                   hit;
    logic [`BPM_FRM_W-1:0]                  dat;
  } bpm_cache_st_type;

  typedef struct packed {
    bpm_state_type         st;
    logic                  own_dma;
    logic [21:0]           dadr;
    logic [`BPM_IDX_W-1:0] cidx;
    logic [31:0]           wbuf;
    logic [13:0]           base;
    logic                  rb_v;
    logic [`BPM_IDX_W-1:0] rb_idx;
    logic [31:0]           rb_dat;
    logic [1:0]            pg_sync;
    logic                  pg_prev;
    logic                  cpu_ack;
    logic                  cpu_retry;
    logic [31:0]           cpu_rdata;
    logic                  dma_ack;
    logic                  dma_noresp;
    logic [28:0]           dma_maddr;
    logic                  mem_req;
    logic                  mem_we;
    logic [28:0]           mem_addr;
    logic [31:0]           mem_wdata;
  } bpm_top_st_type;
endpackage

// *** core/bpm_cache.sv ***
// Purpose: fully associative cache of page map entries
// Assumes: one lookup per cycle, result one cycle later
// Notes:   only valid entries are ever filled
`timescale 1ns/1ps
`include "bpm_defines.svh"
module bpm_cache
  import bpm_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [`BPM_IDX_W-1:0] lk_tag_i,
  output logic                       hit_o,
  output logic [`BPM_FRM_W-1:0]      dat_o,
  input  wire logic                  fill_i,
  input  wire logic [`BPM_IDX_W-1:0] fill_tag_i,
  input  wire logic [`BPM_FRM_W-1:0] fill_dat_i,
  input  wire logic                  inv_one_i,
  input  wire logic [`BPM_IDX_W-1:0] inv_tag_i,
  input  wire logic                  inv_all_i
);
  bpm_cache_st_type s_q;
  bpm_cache_st_type s_d;

  always_comb begin
    s_d     = s_q;
    s_d.hit = 1'b0;
    s_d.dat = '0;
    for (int i = 0; i < `BPM_CACHE_N; i++) begin
      if (s_q.vld[i] && s_q.tag[i] == lk_tag_i && !inv_all_i) begin
        s_d.hit = 1'b1;
        s_d.dat = s_q.frm[i];
      end
      if (inv_one_i && s_q.tag[i] == inv_tag_i) begin
        s_d.vld[i] = 1'b0;
      end
    end
    // round-robin victim, no recency tracking to keep the cam small
    if (fill_i) begin
      s_d.vld[s_q.ptr] = 1'b1;
      s_d.tag[s_q.ptr] = fill_tag_i;
      s_d.frm[s_q.ptr] = fill_dat_i;
      s_d.ptr          = s_q.ptr + 1'b1;
    end
    if (inv_all_i) begin
      s_d.vld = '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hit_o = s_q.hit;
  assign dat_o = s_q.dat;

  property p_inv_all;
    @(posedge clk_i) disable iff (rst_i)
      inv_all_i |=> s_q.vld == '0 && !s_q.hit;
  endproperty
  a_inv_all: assert property (p_inv_all) else $error("cache not cleared");

  property p_fill_rr;
    @(posedge clk_i) disable iff (rst_i)
      fill_i && !inv_all_i |=> s_q.vld[$past(s_q.ptr)] && s_q.ptr == $past(s_q.ptr) + 4'h1;
  endproperty
  a_fill_rr: assert property (p_fill_rr) else $error("fill slot wrong");
endmodule

// *** core/bpm_top.sv ***
// Purpose: page map access for bus dma translation and cpu map window
// Assumes: cpu, dma and memory ports run on MCLK_I; POWER_GOOD_I is a pin
// Notes:   requests are levels held until their answer pulse
//
// Functional notes
// - 8192 entries, one per bus page
// - entries live in 32KB main memory
// - storage base from map base register
// - entry index from address bits 14:2
// - invalid entry means no bus response
// - entry bits 30:20 read as zero
// - frame gives memory bits 28:9
// - entries have no reset value
// - sixteen entry fully associative cache
// - never request expansion bus for map
// - window not reachable from expansion bus
// - cpu hit arbitrates with dma, returns data
// - cpu miss retries, fetches, serves retry
// - cpu read never loads the cache
// - cpu write latched, completed, then stored
// - cpu write invalidates cached copy
// - cpu write never updates cached copy
// - dma miss fetches entry before continuing
// - clear cache on reset, invalidate, base
// - dma refused while external access disabled
`timescale 1ns/1ps
`include "bpm_defines.svh"
module bpm_top
  import bpm_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  input  wire logic        POWER_GOOD_I,
  input  wire logic        EXT_ACCESS_EN_I,
  input  wire logic        INVAL_ALL_REQ_I,
  input  wire logic        IO_RESET_WRITE_I,
  input  wire logic        MAP_BASE_WE_I,
  input  wire logic [31:0] MAP_BASE_I,
  input  wire logic        CPU_REQ_I,
  input  wire logic        CPU_WE_I,
  input  wire logic [31:0] CPU_ADDR_I,
  input  wire logic [31:0] CPU_WDATA_I,
  output logic             CPU_ACK_O,
  output logic             CPU_RETRY_O,
  output logic [31:0]      CPU_RDATA_O,
  input  wire logic        DMA_REQ_I,
  input  wire logic [21:0] DMA_ADDR_I,
  output logic             DMA_ACK_O,
  output logic             DMA_NORESP_O,
  output logic [28:0]      DMA_MADDR_O,
  output logic             MEM_REQ_O,
  output logic             MEM_WE_O,
  output logic [28:0]      MEM_ADDR_O,
  output logic [31:0]      MEM_WDATA_O,
  input  wire logic        MEM_ACK_I,
  input  wire logic [31:0] MEM_RDATA_I
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [28:0] f_entry_addr(input logic [13:0] base,
                                               input logic [`BPM_IDX_W-1:0] idx);
    f_entry_addr = {base, idx, 2'b00};
  endfunction

  function automatic logic [28:0] f_maddr(input logic [`BPM_FRM_W-1:0] frm,
                                          input logic [21:0] adr);
    f_maddr = {frm, adr[`BPM_PAGE_LSB-1:0]};
  endfunction

  function automatic logic [31:0] f_clean(input logic [31:0] e);
    f_clean = e;
    f_clean[`BPM_MBZ_HI:`BPM_MBZ_LO] = '0;
  endfunction

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  bpm_top_st_type        s_q;
  bpm_top_st_type        s_d;
  logic                  c_hit;
  logic [`BPM_FRM_W-1:0] c_dat;
  logic [`BPM_IDX_W-1:0] lk_tag;
  logic                  fill;
  logic                  inv_one;
  logic                  inv_all;
  logic                  pg_neg;
  logic                  cpu_win;
  logic                  cpu_idx_ok;
  logic                  idle_free;
  logic                  dma_take;
  logic                  dma_refuse;
  logic                  cpu_take;
  logic [`BPM_IDX_W-1:0] cpu_idx;

  // window lives in local I/O space only; no expansion-bus path reaches it
  assign cpu_win = CPU_ADDR_I >= `BPM_WIN_FIRST && CPU_ADDR_I <= `BPM_WIN_LAST
                   && CPU_ADDR_I[1:0] == 2'b00;
  assign cpu_idx    = CPU_ADDR_I[14:2];
  assign cpu_idx_ok = cpu_win;
  assign pg_neg     = s_q.pg_prev && !s_q.pg_sync[1];
  assign inv_all    = pg_neg || INVAL_ALL_REQ_I || IO_RESET_WRITE_I
                      || MAP_BASE_WE_I;
  assign idle_free  = s_q.st == ST_IDLE;
  // dma wins the single lookup port; a waiting cpu read is served next
  assign dma_take   = idle_free && DMA_REQ_I && !s_q.dma_ack
                      && !s_q.dma_noresp;
  assign dma_refuse = dma_take && !EXT_ACCESS_EN_I;
  assign cpu_take   = idle_free && !dma_take && CPU_REQ_I && cpu_idx_ok
                      && !s_q.cpu_ack && !s_q.cpu_retry;
  assign lk_tag     = dma_take ? DMA_ADDR_I[21:9] : cpu_idx;
  assign inv_one    = cpu_take && CPU_WE_I;
  assign fill       = s_q.st == ST_MRD && MEM_ACK_I && s_q.own_dma
                      && MEM_RDATA_I[`BPM_VALID_BIT];

  // ----------------------------------------------------------------
  // map cache
  // ----------------------------------------------------------------
  bpm_cache bpm_cache_i (
    .clk_i      (MCLK_I),
    .rst_i      (RST_I),
    .lk_tag_i   (lk_tag),
    .hit_o      (c_hit),
    .dat_o      (c_dat),
    .fill_i     (fill),
    .fill_tag_i (s_q.dadr[21:9]),
    .fill_dat_i (MEM_RDATA_I[`BPM_FRM_W-1:0]),
    .inv_one_i  (inv_one),
    .inv_tag_i  (cpu_idx),
    .inv_all_i  (inv_all)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d            = s_q;
    s_d.pg_sync    = {s_q.pg_sync[0], POWER_GOOD_I};
    s_d.pg_prev    = s_q.pg_sync[1];
    s_d.cpu_ack    = 1'b0;
    s_d.cpu_retry  = 1'b0;
    s_d.dma_ack    = 1'b0;
    s_d.dma_noresp = 1'b0;
    if (MAP_BASE_WE_I) begin
      s_d.base = MAP_BASE_I[`BPM_BASE_MSB:`BPM_BASE_LSB];
    end
    if (inv_all) begin
      s_d.rb_v = 1'b0;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        if (dma_refuse) begin
          s_d.dma_noresp = 1'b1;
        end else if (dma_take) begin
          s_d.own_dma = 1'b1;
          s_d.dadr    = DMA_ADDR_I;
          s_d.st      = ST_LOOK;
        end else if (cpu_take && CPU_WE_I) begin
          // the cpu cycle ends now; memory is written afterwards
          s_d.wbuf      = CPU_WDATA_I;
          s_d.cidx      = cpu_idx;
          s_d.cpu_ack   = 1'b1;
          s_d.mem_req   = 1'b1;
          s_d.mem_we    = 1'b1;
          s_d.mem_addr  = f_entry_addr(s_q.base, cpu_idx);
          s_d.mem_wdata = s_d.wbuf;
          if (s_q.rb_idx == cpu_idx) begin
            s_d.rb_v = 1'b0;
          end
          s_d.st = ST_MWR;
        end else if (cpu_take && s_q.rb_v && s_q.rb_idx == cpu_idx) begin
          s_d.cpu_ack   = 1'b1;
          s_d.cpu_rdata = s_q.rb_dat;
          s_d.rb_v      = 1'b0;
        end else if (cpu_take) begin
          s_d.own_dma = 1'b0;
          s_d.cidx    = cpu_idx;
          s_d.st      = ST_LOOK;
        end
      end
      ST_LOOK: begin
        if (c_hit && s_q.own_dma) begin
          s_d.dma_ack   = 1'b1;
          s_d.dma_maddr = f_maddr(c_dat, s_q.dadr);
          s_d.st        = ST_IDLE;
        end else if (c_hit) begin
          s_d.cpu_ack   = 1'b1;
          s_d.cpu_rdata = {1'b1, 11'h000, c_dat};
          s_d.st        = ST_IDLE;
        end else begin
          // only the local processor bus is used for the fetch
          s_d.cpu_retry = !s_q.own_dma;
          s_d.mem_req   = 1'b1;
          s_d.mem_we    = 1'b0;
          s_d.mem_addr  = f_entry_addr(s_q.base,
                                       s_q.own_dma ? s_q.dadr[21:9] : s_q.cidx);
          s_d.st        = ST_MRD;
        end
      end
      ST_MRD: begin
        if (MEM_ACK_I) begin
          s_d.mem_req = 1'b0;
          s_d.st      = ST_IDLE;
          if (s_q.own_dma && MEM_RDATA_I[`BPM_VALID_BIT]) begin
            s_d.dma_ack   = 1'b1;
            s_d.dma_maddr = f_maddr(MEM_RDATA_I[`BPM_FRM_W-1:0], s_q.dadr);
          end else if (s_q.own_dma) begin
            s_d.dma_noresp = 1'b1;
          end else if (!inv_all) begin
            s_d.rb_v   = 1'b1;
            s_d.rb_idx = s_q.cidx;
            s_d.rb_dat = f_clean(MEM_RDATA_I);
          end
        end
      end
      ST_MWR: begin
        if (MEM_ACK_I) begin
          s_d.mem_req = 1'b0;
          s_d.mem_we  = 1'b0;
          s_d.st      = ST_IDLE;
        end
      end
      default: begin
        s_d.st      = ST_IDLE;
        s_d.mem_req = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_q      <= '0;
      s_q.st   <= ST_IDLE;
      s_q.base <= `BPM_BASE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign CPU_ACK_O    = s_q.cpu_ack;
  assign CPU_RETRY_O  = s_q.cpu_retry;
  assign CPU_RDATA_O  = s_q.cpu_rdata;
  assign DMA_ACK_O    = s_q.dma_ack;
  assign DMA_NORESP_O = s_q.dma_noresp;
  assign DMA_MADDR_O  = s_q.dma_maddr;
  assign MEM_REQ_O    = s_q.mem_req;
  assign MEM_WE_O     = s_q.mem_we;
  assign MEM_ADDR_O   = s_q.mem_addr;
  assign MEM_WDATA_O  = s_q.mem_wdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_refuse;
    @(posedge MCLK_I) disable iff (RST_I)
      dma_refuse |=> DMA_NORESP_O && !DMA_ACK_O && !MEM_REQ_O;
  endproperty
  a_refuse: assert property (p_refuse) else $error("dma not refused");

  property p_invalid;
    @(posedge MCLK_I) disable iff (RST_I)
      s_q.st == ST_MRD && MEM_ACK_I && s_q.own_dma && !MEM_RDATA_I[31]
      |=> DMA_NORESP_O && !DMA_ACK_O;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid entry answered");

  property p_page;
    @(posedge MCLK_I) disable iff (RST_I)
      DMA_ACK_O |-> DMA_MADDR_O[8:0] == s_q.dadr[8:0];
  endproperty
  a_page: assert property (p_page) else $error("page offset changed");

  property p_entry_addr;
    @(posedge MCLK_I) disable iff (RST_I)
      $rose(MEM_REQ_O) |-> MEM_ADDR_O[28:15] == $past(s_q.base) && MEM_ADDR_O[1:0] == 2'b00;
  endproperty
  a_entry_addr: assert property (p_entry_addr) else $error("entry address wrong");

  property p_retry;
    @(posedge MCLK_I) disable iff (RST_I)
      s_q.st == ST_LOOK && !s_q.own_dma && !c_hit
      |=> CPU_RETRY_O && MEM_REQ_O && !MEM_WE_O;
  endproperty
  a_retry: assert property (p_retry) else $error("miss without retry");

  property p_no_cpu_fill;
    @(posedge MCLK_I) disable iff (RST_I)
      s_q.st == ST_MRD && MEM_ACK_I && !s_q.own_dma |=> $stable(bpm_cache_i.s_q.ptr);
  endproperty
  a_no_cpu_fill: assert property (p_no_cpu_fill) else $error("cpu read filled");

  property p_write;
    @(posedge MCLK_I) disable iff (RST_I)
      cpu_take && CPU_WE_I |-> inv_one ##1 CPU_ACK_O && MEM_REQ_O && MEM_WE_O
      && MEM_WDATA_O == $past(CPU_WDATA_I);
  endproperty
  a_write: assert property (p_write) else $error("write not posted");

  property p_zero;
    @(posedge MCLK_I) disable iff (RST_I)
      CPU_ACK_O && !MEM_WE_O |-> CPU_RDATA_O[30:20] == 11'h000;
  endproperty
  a_zero: assert property (p_zero) else $error("reserved bits set");

  property p_dma_first;
    @(posedge MCLK_I) disable iff (RST_I)
      idle_free && DMA_REQ_I && EXT_ACCESS_EN_I && !s_q.dma_ack && !s_q.dma_noresp
      && CPU_REQ_I && cpu_win |=> s_q.st == ST_LOOK && s_q.own_dma && !CPU_ACK_O;
  endproperty
  a_dma_first: assert property (p_dma_first) else $error("lookup port clash");

  property p_fetch_first;
    @(posedge MCLK_I) disable iff (RST_I)
      s_q.st == ST_LOOK && s_q.own_dma && !c_hit
      |=> MEM_REQ_O && !MEM_WE_O && !DMA_ACK_O && !DMA_NORESP_O;
  endproperty
  a_fetch_first: assert property (p_fetch_first) else $error("dma miss not fetched");

  property p_buf_serve;
    @(posedge MCLK_I) disable iff (RST_I)
      cpu_take && !CPU_WE_I && s_q.rb_v && s_q.rb_idx == cpu_idx
      |=> CPU_ACK_O && CPU_RDATA_O == $past(s_q.rb_dat);
  endproperty
  a_buf_serve: assert property (p_buf_serve) else $error("retry not served");

  property p_no_wr_update;
    @(posedge MCLK_I) disable iff (RST_I)
      inv_one |=> $stable(bpm_cache_i.s_q.frm) && $stable(bpm_cache_i.s_q.tag);
  endproperty
  a_no_wr_update: assert property (p_no_wr_update) else $error("cached copy updated");

  property p_wr_hold;
    @(posedge MCLK_I) disable iff (RST_I)
      MEM_REQ_O && MEM_WE_O && !MEM_ACK_I
      |=> MEM_REQ_O && $stable(MEM_WDATA_O) && $stable(MEM_ADDR_O);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("posted write lost");

  property p_base_load;
    @(posedge MCLK_I) disable iff (RST_I)
      MAP_BASE_WE_I |=> s_q.base == $past(MAP_BASE_I[`BPM_BASE_MSB:`BPM_BASE_LSB]);
  endproperty
  a_base_load: assert property (p_base_load) else $error("map base not loaded");
endmodule

// *** bench/bpm_mem_model.sv ***
// Purpose: main memory partner holding the page map store
// Assumes: driven from MEM_* ports of bpm_top, one request at a time
// Notes:   lat_i sets the wait before each ack; idle read data toggles
`timescale 1ns/1ps
module bpm_mem_model (
  input  wire logic        clk_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [28:0] addr_i,
  input  wire logic [31:0] wdata_i,
  output logic             ack_o,
  output logic [31:0]      rdata_o,
  output logic [15:0]      rd_cnt_o,
  output logic [28:0]      last_addr_o
);
  logic [31:0] mem [0:8191];
  logic [3:0]  wait_q;
  // ----------------------------------------------------------------
  // storage and answer
  // ----------------------------------------------------------------
  initial begin
    // contents are never reset, so stale entries start invalid junk
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 32'(i);
    end
    ack_o = 1'b0;
    rdata_o = 32'h0000_0000;
    rd_cnt_o = 16'h0000;
    last_addr_o = 29'h0000_0000;
    wait_q = 4'h0;
  end
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    // read data is garbage outside the ack cycle
    rdata_o <= ~rdata_o;
    if (!req_i || ack_o) begin
      wait_q <= 4'h0;
    end else if (wait_q < lat_i) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      ack_o <= 1'b1;
      last_addr_o <= addr_i;
      if (we_i) begin
        mem[addr_i[14:2]] <= wdata_i;
      end else begin
        rdata_o <= mem[addr_i[14:2]];
        rd_cnt_o <= rd_cnt_o + 16'h0001;
      end
    end
  end
endmodule

// *** bench/test_bpm_top.sv ***
// Purpose: self-checking bench for bpm_top
// Assumes: inputs change at the falling edge of MCLK_I
// Notes:   memory partner answers with a latency set per scenario
`timescale 1ns/1ps
`include "bpm_defines.svh"
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin bad_count++; \
  $display("MISMATCH %s expected %h seen %h", n, e, s); end end
module test_bpm_top
  import bpm_pkg::*;
;
  logic mclk, rst, pgood, ext_en, inval, io_rst, base_we, cpu_req, cpu_we, dma_req;
  logic [31:0] base_in, cpu_addr, cpu_wdata, mem_rdata, CPU_RDATA_O;
  logic [21:0] dma_addr;
  logic [3:0]  lat;
  logic [13:0] cur_base;
  logic [15:0] rd_cnt;
  logic [28:0] last_addr, DMA_MADDR_O, MEM_ADDR_O;
  logic CPU_ACK_O, CPU_RETRY_O, DMA_ACK_O, DMA_NORESP_O, MEM_REQ_O, MEM_WE_O, mem_ack;
  logic [31:0] MEM_WDATA_O;
  int bad_count, cmp_count;
  bpm_top bpm_top_i (.MCLK_I(mclk), .RST_I(rst), .POWER_GOOD_I(pgood), .EXT_ACCESS_EN_I(ext_en),
    .INVAL_ALL_REQ_I(inval), .IO_RESET_WRITE_I(io_rst), .MAP_BASE_WE_I(base_we), .MAP_BASE_I(base_in),
    .CPU_REQ_I(cpu_req), .CPU_WE_I(cpu_we), .CPU_ADDR_I(cpu_addr), .CPU_WDATA_I(cpu_wdata),
    .CPU_ACK_O(CPU_ACK_O), .CPU_RETRY_O(CPU_RETRY_O), .CPU_RDATA_O(CPU_RDATA_O), .DMA_REQ_I(dma_req),
    .DMA_ADDR_I(dma_addr), .DMA_ACK_O(DMA_ACK_O), .DMA_NORESP_O(DMA_NORESP_O), .DMA_MADDR_O(DMA_MADDR_O),
    .MEM_REQ_O(MEM_REQ_O), .MEM_WE_O(MEM_WE_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O),
    .MEM_ACK_I(mem_ack), .MEM_RDATA_I(mem_rdata));
  bpm_mem_model bpm_mem_model_i (.clk_i(mclk), .lat_i(lat), .req_i(MEM_REQ_O), .we_i(MEM_WE_O),
    .addr_i(MEM_ADDR_O), .wdata_i(MEM_WDATA_O), .ack_o(mem_ack), .rdata_o(mem_rdata),
    .rd_cnt_o(rd_cnt), .last_addr_o(last_addr));
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
    repeat (5) @(negedge mclk);
  endtask
  // a retry is answered by asking again, as the cpu must
  task automatic cpu_op(input logic we, input logic [12:0] i, input logic [31:0] wd,
                        output logic [31:0] rd, output logic retried);
    logic done;
    int n;
    done = 1'b0;
    retried = 1'b0;
    n = 0;
    while (!done && n < 300) begin
      cpu_we = we;
      cpu_addr = `BPM_WIN_FIRST + {17'h0_0000, i, 2'b00};
      cpu_wdata = wd;
      cpu_req = 1'b1;
      @(negedge mclk);
      while (CPU_ACK_O !== 1'b1 && CPU_RETRY_O !== 1'b1 && n < 300) begin
        @(negedge mclk);
        n++;
      end
      cpu_req = 1'b0;
      if (CPU_RETRY_O === 1'b1) retried = 1'b1;
      else done = 1'b1;
      rd = CPU_RDATA_O;
      @(negedge mclk);
    end
    `CHK("cpu answer", 1'b1, done)
  endtask
  task automatic mem_idle();
    int n;
    n = 0;
    while (MEM_REQ_O !== 1'b0 && n < 100) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic wr_entry(input logic [12:0] i, input logic [31:0] v);
    logic [31:0] rd;
    logic r;
    cpu_op(1'b1, i, v, rd, r);
    `CHK("write retry", 1'b0, r)
    mem_idle();
    `CHK("write address", {cur_base, i, 2'b00}, last_addr)
    `CHK("stored entry", v, bpm_mem_model_i.mem[i])
  endtask
  task automatic rd_entry(input logic [12:0] i, input logic [31:0] v, input logic exp_retry);
    logic [31:0] rd;
    logic r;
    cpu_op(1'b0, i, 32'h0000_0000, rd, r);
    `CHK("read retry", exp_retry, r)
    `CHK("read data", v, rd)
    `CHK("read zero bits", 11'h000, rd[30:20])
  endtask
  task automatic dma_chk(input logic [12:0] i, input logic ok, input logic [19:0] frm, input logic [15:0] f);
    logic [15:0] c0;
    int n;
    c0 = rd_cnt;
    n = 0;
    dma_addr = {i, 9'h1A7};
    dma_req = 1'b1;
    @(negedge mclk);
    while (DMA_ACK_O !== 1'b1 && DMA_NORESP_O !== 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    dma_req = 1'b0;
    `CHK("dma ack", ok, DMA_ACK_O)
    `CHK("dma noresp", !ok, DMA_NORESP_O)
    if (ok) `CHK("dma maddr", {frm, 9'h1A7}, DMA_MADDR_O)
    `CHK("dma fetches", f, rd_cnt - c0)
    @(negedge mclk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_map();
    lat = 4'h0;
    wr_entry(13'd5, 32'h8001_2345);
    wr_entry(13'h1FFF, 32'h800F_FFFF);
    dma_chk(13'd5, 1'b1, 20'h1_2345, 16'h1);
    dma_chk(13'h1FFF, 1'b1, 20'hF_FFFF, 16'h1);
    dma_chk(13'd5, 1'b1, 20'h1_2345, 16'h0);
    fork
      rd_entry(13'd5, 32'h8001_2345, 1'b0);
      dma_chk(13'h1FFF, 1'b1, 20'hF_FFFF, 16'h0);
    join
  endtask
  task automatic t_cpu_miss();
    lat = 4'h3;
    wr_entry(13'd9, 32'h8000_0ABC);
    rd_entry(13'd9, 32'h8000_0ABC, 1'b1);
    dma_chk(13'd9, 1'b1, 20'h0_0ABC, 16'h1);
    wr_entry(13'd5, 32'h8005_4321);
    dma_chk(13'd5, 1'b1, 20'h5_4321, 16'h1);
    wr_entry(13'd7, 32'h0001_1111);
    dma_chk(13'd7, 1'b0, 20'h0_0000, 16'h1);
    ext_en = 1'b0;
    dma_chk(13'd5, 1'b0, 20'h0_0000, 16'h0);
    ext_en = 1'b1;
  endtask
  task automatic t_clear();
    for (int k = 0; k < 4; k++) begin
      dma_chk(13'd5, 1'b1, 20'h5_4321, 16'h0);
      case (k)
        0: begin
          base_in = 32'h0123_8000;
          cur_base = base_in[28:15];
          pulse(base_we);
        end
        1: pulse(inval);
        2: pulse(io_rst);
        default: begin
          pgood = 1'b0;
          repeat (5) @(negedge mclk);
          pulse(pgood);
          pgood = 1'b1;
        end
      endcase
      dma_chk(13'd5, 1'b1, 20'h5_4321, 16'h1);
      `CHK("fetch base", {cur_base, 13'd5, 2'b00}, last_addr)
    end
  endtask
  task automatic t_window();
    logic seen;
    for (int k = 0; k < 3; k++) begin
      seen = 1'b0;
      cpu_we = 1'b0;
      cpu_addr = k == 0 ? `BPM_WIN_FIRST - 32'h0000_0004 : k == 1 ? `BPM_WIN_LAST + 32'h0000_0004
                 : `BPM_WIN_FIRST + 32'h0000_0006;
      cpu_req = 1'b1;
      repeat (12) begin
        @(negedge mclk);
        seen = seen | CPU_ACK_O | CPU_RETRY_O | MEM_REQ_O;
      end
      cpu_req = 1'b0;
      @(negedge mclk);
      `CHK("outside window", 1'b0, seen)
    end
  endtask
  // ----------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
  initial begin
    {pgood, ext_en, inval, io_rst, base_we, cpu_req, cpu_we, dma_req} = 8'hC0;
    {base_in, cpu_addr, cpu_wdata, dma_addr, cur_base} = '0;
    rst = 1'b1;
    lat = 4'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(negedge mclk);
    `CHK("reset outputs", 4'h0, {CPU_ACK_O, DMA_ACK_O, MEM_REQ_O, CPU_RETRY_O})
    rst = 1'b0;
    @(negedge mclk);
    t_map();
    t_cpu_miss();
    t_clear();
    t_window();
    summarize();
  end
endmodule
